// >>> core/pmc_mode_ctrl.sv
// Operating-mode controller: mode sequencing, process-image cycle order,
// supervision, indicators, analogue safe values and AXI4-Lite registers.
// Assumes an external program engine that acknowledges each request with ENG_DONE
// and halts itself when it reports a breakpoint.
module pmc_mode_ctrl
	import pmc_pkg::*;
#(
	parameter int unsigned NCH          = 2,
	parameter int unsigned WDG_CYC      = WDG_CYC_DEF,
	parameter int unsigned BLINK_MIN    = BLINK_MIN_DEF,
	parameter int unsigned BLINK_HALF   = BLINK_HALF_DEF,
	parameter int unsigned MR_HOLD      = MR_HOLD_DEF,
	parameter logic [15:0] AO_LIVE_ZERO = AO_LIVE_ZERO_DEF
) (
	input  wire logic                   CLK,
	input  wire logic                   RESET_N,
	input  wire logic [7:0]             S_AXI_AWADDR,
	input  wire logic                   S_AXI_AWVALID,
	output logic                        S_AXI_AWREADY,
	input  wire logic [31:0]            S_AXI_WDATA,
	input  wire logic [3:0]             S_AXI_WSTRB,
	input  wire logic                   S_AXI_WVALID,
	output logic                        S_AXI_WREADY,
	output logic [1:0]                  S_AXI_BRESP,
	output logic                        S_AXI_BVALID,
	input  wire logic                   S_AXI_BREADY,
	input  wire logic [7:0]             S_AXI_ARADDR,
	input  wire logic                   S_AXI_ARVALID,
	output logic                        S_AXI_ARREADY,
	output logic [31:0]                 S_AXI_RDATA,
	output logic [1:0]                  S_AXI_RRESP,
	output logic                        S_AXI_RVALID,
	input  wire logic                   S_AXI_RREADY,
	input  wire logic                   SWITCH_RUN,
	input  wire logic                   SWITCH_MR,
	output pmc_eng_req_t                ENG_REQ,
	input  wire logic                   ENG_DONE,
	input  wire logic                   BRK_HIT,
	input  wire logic [1:0]             BRK_ID,
	input  wire logic                   WDG_KICK,
	output logic                        OUT_INHIBIT,
	output logic                        RUN_INDICATOR,
	output logic                        STOP_LED,
	output logic                        TIMER_EN,
	output logic                        MEM_ERASE,
	input  wire logic [NCH-1:0][15:0]   AO_IN,
	output logic [NCH-1:0][15:0]        AO_OUT
);

	if (NCH < 1 || NCH > 2) begin : g_chk
		$error("NCH must be 1 or 2");
	end
	if (WDG_CYC < 2 || BLINK_MIN < 2 || BLINK_HALF < 2 || MR_HOLD < 2) begin : g_chk_t
		$error("Timing counts must be at least 2");
	end

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RESET_N);

	function automatic logic [31:0] pmc_merge(input logic [31:0] old, input logic [31:0] nw,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[8*b +: 8] = nw[8*b +: 8];
			end
		end
		return r;
	endfunction

	// Register state
	logic                  run_req, next_run_req;
	logic [BRK_N-1:0]      brk_def, next_brk_def;
	logic [BRK_N-1:0]      brk_act, next_brk_act;
	logic [15:0]           cyc_limit, next_cyc_limit;
	logic [31:0]           ao_cfg, next_ao_cfg;
	logic [31:0]           ao_subst, next_ao_subst;
	logic                  bvalid, next_bvalid;
	logic [1:0]            bresp, next_bresp;
	logic                  rvalid, next_rvalid;
	logic [31:0]           rdata, next_rdata;
	logic [1:0]            rresp, next_rresp;
	logic                  wr_fire;
	logic [31:0]           wmask;
	logic [31:0]           brk_merge, lim_merge;
	logic                  resume_wr, step_wr, erase_wr, clr_wr;
	// Mode state
	pmc_mode_t             mode, next_mode;
	pmc_phase_t            phase, next_phase;
	logic                  issued, next_issued;
	logic                  stepping, next_stepping;
	logic                  wdg_fault, next_wdg_fault;
	logic                  cyc_fault, next_cyc_fault;
	logic                  step_refused, next_step_refused;
	pmc_eng_req_t          next_eng;
	logic                  go_ok, brk_take, wdg_exp, cyc_exp, step_ok;
	logic [3:0]            brk_en4;
	// Counters and indicators
	logic [31:0]           wdg_cnt, next_wdg_cnt;
	logic [7:0]            us_div, next_us_div;
	logic [15:0]           cyc_us, next_cyc_us;
	logic [31:0]           blink_cnt, next_blink_cnt;
	logic                  blink_act, next_blink_act;
	logic [31:0]           half_cnt, next_half_cnt;
	logic                  blink_ph, next_blink_ph;
	logic [31:0]           mr_cnt, next_mr_cnt;
	logic                  mr_armed, next_mr_armed;
	logic                  mr_prev;
	logic                  next_inhibit, next_run_indicator, next_stop_led, next_erase;
	logic [NCH-1:0][15:0]  next_ao;

	// AXI4-Lite slave: address and data are taken together in one cycle
	always_comb begin
		wr_fire        = S_AXI_AWVALID && S_AXI_WVALID && !bvalid;
		S_AXI_AWREADY  = wr_fire;
		S_AXI_WREADY   = wr_fire;
		S_AXI_ARREADY  = !rvalid;
		wmask          = pmc_merge(32'h0000_0000, S_AXI_WDATA, S_AXI_WSTRB);
		brk_merge      = pmc_merge({26'h0, brk_act, brk_def}, S_AXI_WDATA, S_AXI_WSTRB);
		lim_merge      = pmc_merge({16'h0, cyc_limit}, S_AXI_WDATA, S_AXI_WSTRB);
		next_run_req   = run_req;
		next_brk_def   = brk_def;
		next_brk_act   = brk_act;
		next_cyc_limit = cyc_limit;
		next_ao_cfg    = ao_cfg;
		next_ao_subst  = ao_subst;
		resume_wr      = 1'b0;
		step_wr        = 1'b0;
		erase_wr       = 1'b0;
		clr_wr         = 1'b0;
		next_bvalid    = bvalid && !S_AXI_BREADY;
		next_bresp     = bresp;
		if (wr_fire) begin
			next_bvalid = 1'b1;
			next_bresp  = RESP_OKAY;
			case (S_AXI_AWADDR)
				ADDR_CTRL: begin
					if (S_AXI_WSTRB[0]) begin
						next_run_req = S_AXI_WDATA[CTRL_RUN];
					end
					resume_wr = wmask[CTRL_RESUME];
					step_wr   = wmask[CTRL_STEP];
					erase_wr  = wmask[CTRL_ERASE];
					clr_wr    = wmask[CTRL_CLR];
				end
				ADDR_STATUS: begin
				end
				ADDR_BRK: begin
					{next_brk_act, next_brk_def} = brk_merge[5:0];
				end
				ADDR_CYC_LIMIT: begin
					next_cyc_limit = lim_merge[15:0];
					// A limit below the minimum would trip on every cycle
					if (next_cyc_limit < CYC_LIMIT_MIN) begin
						next_cyc_limit = CYC_LIMIT_MIN;
					end
				end
				ADDR_AO_CFG: begin
					next_ao_cfg = pmc_merge(ao_cfg, S_AXI_WDATA, S_AXI_WSTRB);
				end
				ADDR_AO_SUBST: begin
					next_ao_subst = pmc_merge(ao_subst, S_AXI_WDATA, S_AXI_WSTRB);
				end
				default: begin
					next_bresp = RESP_DECERR;
				end
			endcase
		end
		next_rvalid = rvalid && !S_AXI_RREADY;
		next_rdata  = rdata;
		next_rresp  = rresp;
		if (S_AXI_ARVALID && !rvalid) begin
			next_rvalid = 1'b1;
			next_rresp  = RESP_OKAY;
			next_rdata  = 32'h0000_0000;
			case (S_AXI_ARADDR)
				ADDR_CTRL: begin
					next_rdata[CTRL_RUN] = run_req;
				end
				ADDR_STATUS: begin
					next_rdata[ST_MODE +: 2]  = mode;
					next_rdata[ST_PHASE +: 3] = phase;
					next_rdata[ST_WDG]        = wdg_fault;
					next_rdata[ST_CYC]        = cyc_fault;
					next_rdata[ST_STEP_REF]   = step_refused;
					next_rdata[ST_BLINK]      = blink_act;
				end
				ADDR_BRK: begin
					next_rdata[5:0] = {brk_act, brk_def};
				end
				ADDR_CYC_LIMIT: begin
					next_rdata[15:0] = cyc_limit;
				end
				ADDR_AO_CFG: begin
					next_rdata = ao_cfg;
				end
				ADDR_AO_SUBST: begin
					next_rdata = ao_subst;
				end
				default: begin
					next_rresp = RESP_DECERR;
				end
			endcase
		end
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			run_req   <= 1'b0;
			brk_def   <= '0;
			brk_act   <= '0;
			cyc_limit <= CYC_LIMIT_MIN;
			ao_cfg    <= 32'h0000_0000;
			ao_subst  <= 32'h0000_0000;
			bvalid    <= 1'b0;
			bresp     <= RESP_OKAY;
			rvalid    <= 1'b0;
			rdata     <= 32'h0000_0000;
			rresp     <= RESP_OKAY;
		end else begin
			run_req   <= next_run_req;
			brk_def   <= next_brk_def;
			brk_act   <= next_brk_act;
			cyc_limit <= next_cyc_limit;
			ao_cfg    <= next_ao_cfg;
			ao_subst  <= next_ao_subst;
			bvalid    <= next_bvalid;
			bresp     <= next_bresp;
			rvalid    <= next_rvalid;
			rdata     <= next_rdata;
			rresp     <= next_rresp;
		end
	end

	assign S_AXI_BVALID = bvalid;
	assign S_AXI_BRESP  = bresp;
	assign S_AXI_RVALID = rvalid;
	assign S_AXI_RDATA  = rdata;
	assign S_AXI_RRESP  = rresp;

	// Mode sequencer and process-image cycle
	always_comb begin
		go_ok    = SWITCH_RUN && run_req;
		// Supervision runs in run only; start-up and hold are never timed
		wdg_exp  = mode == PMC_RUN && !WDG_KICK && wdg_cnt == WDG_CYC - 1;
		cyc_exp  = mode == PMC_RUN && cyc_us >= cyc_limit;
		brk_en4  = {1'b0, brk_def & brk_act};
		brk_take = BRK_HIT && phase == PH_MAIN && brk_en4[BRK_ID];
		step_ok  = $countones(brk_def) <= STEP_MAX_BRK;
		next_mode     = mode;
		next_phase    = phase;
		next_issued   = issued;
		next_stepping = stepping;
		next_eng      = '{go: 1'b0, step: 1'b0, op: PH_IDLE};
		next_wdg_fault    = wdg_exp || (wdg_fault && !clr_wr);
		next_cyc_fault    = cyc_exp || (cyc_fault && !clr_wr);
		next_step_refused = (step_wr && mode == PMC_HOLD && !step_ok) || (step_refused && !clr_wr);
		case (mode)
			PMC_STOP: begin
				// Images and engine state are left untouched here
				if (go_ok && !wdg_fault && !cyc_fault) begin
					next_mode  = PMC_STARTUP;
					next_phase = PH_CLR_IN;
				end
			end
			PMC_STARTUP: begin
				if (!go_ok) begin
					next_mode = PMC_STOP;
				end else if (ENG_DONE && issued) begin
					next_issued = 1'b0;
					case (phase)
						PH_CLR_IN:  next_phase = PH_REMOTE;
						PH_REMOTE:  next_phase = PH_STARTUP;
						default: begin
							next_mode  = PMC_RUN;
							next_phase = PH_CLR_OUT;
						end
					endcase
				end
			end
			PMC_RUN: begin
				if (!go_ok || wdg_exp || cyc_exp) begin
					next_mode = PMC_STOP;
				end else if (brk_take) begin
					next_mode = PMC_HOLD;
				end else if (ENG_DONE && issued) begin
					next_issued = 1'b0;
					case (phase)
						PH_READ_IN:  next_phase = PH_MAIN;
						PH_MAIN:     next_phase = PH_WRITE_OUT;
						default:     next_phase = PH_READ_IN;
					endcase
				end
			end
			PMC_HOLD: begin
				if (!go_ok) begin
					next_mode = PMC_STOP;
				end else if (stepping) begin
					next_stepping = !ENG_DONE;
				end else if (resume_wr) begin
					next_mode = PMC_RUN;
				end else if (step_wr && step_ok) begin
					next_stepping = 1'b1;
					next_eng      = '{go: 1'b1, step: 1'b1, op: phase};
				end
			end
			default: begin
				next_mode = PMC_STOP;
			end
		endcase
		if (next_mode == PMC_STOP) begin
			next_phase    = PH_IDLE;
			next_issued   = 1'b0;
			next_stepping = 1'b0;
		end else if (mode == next_mode && mode != PMC_HOLD && !next_issued) begin
			next_issued = 1'b1;
			next_eng    = '{go: 1'b1, step: 1'b0, op: next_phase};
		end
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			mode         <= PMC_STOP;
			phase        <= PH_IDLE;
			issued       <= 1'b0;
			stepping     <= 1'b0;
			wdg_fault    <= 1'b0;
			cyc_fault    <= 1'b0;
			step_refused <= 1'b0;
			ENG_REQ      <= '{go: 1'b0, step: 1'b0, op: PH_IDLE};
		end else begin
			mode         <= next_mode;
			phase        <= next_phase;
			issued       <= next_issued;
			stepping     <= next_stepping;
			wdg_fault    <= next_wdg_fault;
			cyc_fault    <= next_cyc_fault;
			step_refused <= next_step_refused;
			ENG_REQ      <= next_eng;
		end
	end

	// Supervision, blink, overall reset and output decode
	always_comb begin
		next_wdg_cnt = (mode != PMC_RUN || WDG_KICK) ? 32'h0 : wdg_cnt + 32'h1;
		next_us_div  = (us_div == 8'(US_CYC - 1)) ? 8'h00 : us_div + 8'h01;
		next_cyc_us  = cyc_us;
		// Hold freezes the cycle timer rather than clearing it
		if (mode == PMC_STOP || mode == PMC_STARTUP) begin
			next_cyc_us = 16'h0000;
		end else if (mode == PMC_RUN && phase == PH_WRITE_OUT && ENG_DONE && issued) begin
			next_cyc_us = 16'h0000;
		end else if (mode == PMC_RUN && us_div == 8'(US_CYC - 1) && cyc_us != 16'hFFFF) begin
			next_cyc_us = cyc_us + 16'h0001;
		end
		next_blink_act = blink_act && blink_cnt != BLINK_MIN - 1;
		next_blink_cnt = blink_act ? blink_cnt + 32'h1 : 32'h0;
		if (mode == PMC_STOP && next_mode == PMC_STARTUP) begin
			next_blink_act = 1'b1;
			next_blink_cnt = 32'h0;
		end
		next_half_cnt = (half_cnt == BLINK_HALF - 1) ? 32'h0 : half_cnt + 32'h1;
		next_blink_ph = (half_cnt == BLINK_HALF - 1) ? !blink_ph : blink_ph;
		// Memory reset: hold the switch, release, then tip it again
		next_mr_cnt   = (SWITCH_MR && mode == PMC_STOP && mr_cnt != MR_HOLD - 1) ?
			mr_cnt + 32'h1 : (SWITCH_MR ? mr_cnt : 32'h0);
		next_erase    = mode == PMC_STOP &&
			(erase_wr || (mr_armed && SWITCH_MR && !mr_prev));
		next_mr_armed = mode == PMC_STOP && !next_erase &&
			(mr_armed || (SWITCH_MR && mr_cnt == MR_HOLD - 1));
		// One inhibit serves central and remote outputs alike
		next_inhibit  = next_mode != PMC_RUN;
		next_stop_led = next_mode == PMC_STOP || next_mode == PMC_HOLD;
		if (next_mode == PMC_STARTUP || next_mode == PMC_HOLD || next_blink_act) begin
			next_run_indicator = next_blink_ph;
		end else begin
			next_run_indicator = next_mode == PMC_RUN;
		end
	end

	for (genvar i = 0; i < NCH; i++) begin : g_ao
		logic [15:0] safe;
		always_comb begin
			if (ao_cfg[AO_SUBST_EN + i]) begin
				safe = ao_subst[16*i +: 16];
			end else if (ao_cfg[2*i +: 2] == AO_TYPE_I420) begin
				safe = AO_LIVE_ZERO;
			end else begin
				safe = AO_ZERO;
			end
			next_ao[i] = next_inhibit ? safe : AO_IN[i];
		end
		// Output register lags the configuration by one edge
		AST_AO_SAFE: assert property (OUT_INHIBIT && !$past(ao_cfg[AO_SUBST_EN + i])
			|-> AO_OUT[i] == ($past(ao_cfg[2*i +: 2]) == AO_TYPE_I420 ? AO_LIVE_ZERO : AO_ZERO))
			else $error("Disabled analogue channel not at its safe value");
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			wdg_cnt     <= 32'h0;
			us_div      <= 8'h00;
			cyc_us      <= 16'h0000;
			blink_act   <= 1'b0;
			blink_cnt   <= 32'h0;
			half_cnt    <= 32'h0;
			blink_ph    <= 1'b0;
			mr_cnt      <= 32'h0;
			mr_armed    <= 1'b0;
			mr_prev     <= 1'b0;
			MEM_ERASE   <= 1'b0;
			OUT_INHIBIT <= 1'b1;
			STOP_LED    <= 1'b1;
			RUN_INDICATOR     <= 1'b0;
			TIMER_EN    <= 1'b0;
			AO_OUT      <= '0;
		end else begin
			wdg_cnt     <= next_wdg_cnt;
			us_div      <= next_us_div;
			cyc_us      <= next_cyc_us;
			blink_act   <= next_blink_act;
			blink_cnt   <= next_blink_cnt;
			half_cnt    <= next_half_cnt;
			blink_ph    <= next_blink_ph;
			mr_cnt      <= next_mr_cnt;
			mr_armed    <= next_mr_armed;
			mr_prev     <= SWITCH_MR;
			MEM_ERASE   <= next_erase;
			OUT_INHIBIT <= next_inhibit;
			STOP_LED    <= next_stop_led;
			RUN_INDICATOR     <= next_run_indicator;
			TIMER_EN    <= next_mode == PMC_RUN;
			AO_OUT      <= next_ao;
		end
	end

	AST_STOP_OUTS: assert property (mode == PMC_STOP && !blink_act
		|-> OUT_INHIBIT && STOP_LED && !RUN_INDICATOR && !TIMER_EN)
		else $error("Stop outputs wrong");
	AST_STARTUP_OUTS: assert property (mode == PMC_STARTUP |-> OUT_INHIBIT && !STOP_LED)
		else $error("Start-up outputs wrong");
	AST_RUN_OUTS: assert property (mode == PMC_RUN && !blink_act
		|-> !OUT_INHIBIT && RUN_INDICATOR && !STOP_LED && TIMER_EN)
		else $error("Run outputs wrong");
	AST_HOLD_OUTS: assert property (mode == PMC_HOLD
		|-> OUT_INHIBIT && STOP_LED && !TIMER_EN
		&& ($past(mode) != PMC_HOLD || cyc_us == $past(cyc_us)))
		else $error("Hold outputs wrong");
	AST_BLINK_MIN: assert property ($fell(blink_act) |-> $past(blink_cnt) == BLINK_MIN - 1)
		else $error("Blink ended before its minimum");
	AST_START_ORDER: assert property (mode == PMC_STOP ##1 mode == PMC_STARTUP
		|-> phase == PH_CLR_IN ##1 ENG_REQ.go && ENG_REQ.op == PH_CLR_IN)
		else $error("Start did not begin by clearing inputs");
	AST_FIRST_CYCLE: assert property ($past(mode) == PMC_STARTUP && mode == PMC_RUN
		|-> phase == PH_CLR_OUT && !OUT_INHIBIT)
		else $error("First cycle did not clear output image");
	AST_CYCLE_ORDER: assert property (mode == PMC_RUN && $changed(phase)
		|-> (phase == PH_MAIN) == ($past(phase) == PH_READ_IN))
		else $error("Main routine not preceded by input read");
	AST_BRK_HOLD: assert property (mode == PMC_RUN && go_ok && !wdg_exp && !cyc_exp
		&& brk_take |=> mode == PMC_HOLD && OUT_INHIBIT)
		else $error("Breakpoint did not enter hold");
	AST_WDG_STOP: assert property (wdg_exp |=> mode == PMC_STOP && wdg_fault ##1 OUT_INHIBIT)
		else $error("Watchdog expiry did not stop");
	AST_STEP_REFUSE: assert property (mode == PMC_HOLD && go_ok && !stepping && step_wr
		&& $countones(brk_def) > STEP_MAX_BRK |=> step_refused && !ENG_REQ.go && mode == PMC_HOLD)
		else $error("Single step not refused");
	AST_RESUME: assert property (mode == PMC_HOLD && go_ok && !stepping && resume_wr
		|=> mode == PMC_RUN)
		else $error("Resume did not return to run");

endmodule

// >>> core/pmc_pkg.sv
// Constants, types and register map of the operating-mode controller.
// Assumes a 200 MHz system clock and an AXI4-Lite master for software.
// Function
// - Exactly one of four modes is held: stop, start-up, run or hold.
// - Stop runs no program and preserves counters, timers, flags and images.
// - Stop asserts output inhibit, run indicator off, stop indicator on; the code blinks the run indicator until a start-up blink ends.
// - Stop toward run invokes start-up routine without any time supervision.
// - Start-up keeps output inhibit asserted and stop indicator off.
// - Run indicator blinks from start-up begin for at least 3 s.
// - Finished start-up routine moves the controller into run.
// - Run executes main routine cyclically, timers active, image refreshed per cycle.
// - Run releases output inhibit, run indicator on, stop indicator off.
// - Up to 3 breakpoints; an active one reached in run enters hold.
// - Hold blinks run indicator, lights stop indicator, halts all execution.
// - Hold freezes program timers while the real-time clock keeps running.
// - Hold asserts output inhibit and keeps communication connections.
// - Single step is refused when more than 2 breakpoints are defined.
// - 100 ms watchdog and cycle-time limit of at least 1 ms force stop.
// - Run to stop sets inhibit, disabling central digital and analogue outputs.
// - Disabled analogue outputs give 0 V, 0 mA, 4 mA or substitute values.
// - Remote outputs disable like central ones; remote inputs keep being read.
// - Start clears input image, runs start-up, releases inhibit, first cycle clears outputs.
// - On start the remote station reads its inputs once.
// - Each run cycle reads inputs, runs main routine, then writes outputs.
// - Overall reset erases user memory, requested by switch or programming tool.
package pmc_pkg;

	localparam int unsigned CLK_HZ           = 200_000_000;
	localparam int unsigned WDG_MS           = 100;
	localparam int unsigned BLINK_MIN_MS     = 3000;
	localparam int unsigned BLINK_HALF_MS    = 250;
	localparam int unsigned MR_HOLD_MS       = 3000;
	localparam int unsigned WDG_CYC_DEF      = CLK_HZ / 1000 * WDG_MS;
	localparam int unsigned BLINK_MIN_DEF    = CLK_HZ / 1000 * BLINK_MIN_MS;
	localparam int unsigned BLINK_HALF_DEF   = CLK_HZ / 1000 * BLINK_HALF_MS;
	localparam int unsigned MR_HOLD_DEF      = CLK_HZ / 1000 * MR_HOLD_MS;
	localparam int unsigned US_CYC           = CLK_HZ / 1_000_000;
	localparam logic [15:0] CYC_LIMIT_MIN    = 16'h03E8;

	localparam logic [7:0]  ADDR_CTRL        = 8'h00;
	localparam logic [7:0]  ADDR_STATUS      = 8'h04;
	localparam logic [7:0]  ADDR_BRK         = 8'h08;
	localparam logic [7:0]  ADDR_CYC_LIMIT   = 8'h0C;
	localparam logic [7:0]  ADDR_AO_CFG      = 8'h10;
	localparam logic [7:0]  ADDR_AO_SUBST    = 8'h14;

	localparam int unsigned CTRL_RUN         = 0;
	localparam int unsigned CTRL_RESUME      = 1;
	localparam int unsigned CTRL_STEP        = 2;
	localparam int unsigned CTRL_ERASE       = 3;
	localparam int unsigned CTRL_CLR         = 4;
	localparam int unsigned ST_MODE          = 0;
	localparam int unsigned ST_PHASE         = 2;
	localparam int unsigned ST_WDG           = 5;
	localparam int unsigned ST_CYC           = 6;
	localparam int unsigned ST_STEP_REF      = 7;
	localparam int unsigned ST_BLINK         = 8;
	localparam int unsigned BRK_N            = 3;
	localparam int unsigned BRK_ACT          = 3;
	localparam int unsigned STEP_MAX_BRK     = 2;
	localparam int unsigned AO_SUBST_EN      = 8;

	localparam logic [1:0]  AO_TYPE_I420     = 2'h2;
	localparam logic [15:0] AO_ZERO          = 16'h0000;
	localparam logic [15:0] AO_LIVE_ZERO_DEF = 16'h1999;
	localparam logic [1:0]  RESP_OKAY        = 2'h0;
	localparam logic [1:0]  RESP_DECERR      = 2'h3;

	typedef enum logic [1:0] {
		PMC_STOP    = 2'h0,
		PMC_STARTUP = 2'h1,
		PMC_RUN     = 2'h3,
		PMC_HOLD    = 2'h2
	} pmc_mode_t;

	typedef enum logic [2:0] {
		PH_IDLE      = 3'h0,
		PH_CLR_IN    = 3'h1,
		PH_REMOTE    = 3'h3,
		PH_STARTUP   = 3'h2,
		PH_CLR_OUT   = 3'h6,
		PH_READ_IN   = 3'h7,
		PH_MAIN      = 3'h5,
		PH_WRITE_OUT = 3'h4
	} pmc_phase_t;

	typedef struct packed {
		logic       go;
		logic       step;
		pmc_phase_t op;
	} pmc_eng_req_t;

endpackage

// >>> verif/pmc_eng_model.sv
// Program engine stand-in: one done per go, halts on an armed main routine.
// Assumes the controller link of one outstanding request at a time.
module pmc_eng_model
	import pmc_pkg::*;
(
	input  wire logic         CLK,
	input  wire logic         RESET_N,
	input  wire pmc_eng_req_t REQ,
	input  wire logic         ARM,
	output logic              DONE,
	output logic              HIT
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [1:0] cnt;
	logic       halt;
	// Halted main routine is answered only once the breakpoint is disarmed
	assign HIT  = REQ.go && ARM && REQ.op == PH_MAIN && !REQ.step;
	assign DONE = cnt == 2'h1;
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			cnt  <= 2'h0;
			halt <= 1'b0;
		end else if (HIT) begin
			halt <= 1'b1;
		end else if (REQ.go) begin
			cnt <= 2'h2;
		end else if (halt && !ARM) begin
			halt <= 1'b0;
			cnt  <= 2'h1;
		end else if (cnt != 2'h0) begin
			cnt <= cnt - 2'h1;
		end
	end
endmodule

// >>> verif/tb_pmc_mode_ctrl.sv
// Bench for the mode controller: registers, start order, hold, stop, erase.
// Assumes shortened counts and the engine stand-in on the far side.
module tb_pmc_mode_ctrl;
	timeunit 1ns;
	timeprecision 100ps;
	import pmc_pkg::*;
	logic             clk = 0, rst_n = 0, awv = 0, wv = 0, arv = 0, rre = 0, bre = 0;
	logic             sw_run = 0, sw_mr = 0, arm = 0, nokick = 0;
	logic [3:0]       ws = 4'hF;
	logic [1:0]       bid = 2'h0;
	logic [15:0]      ai = 16'h1234;
	logic [7:0]       awa = 0, ara = 0;
	logic [31:0]      wd = 0, rd, rdata;
	logic [1:0]       br, rr, rsp;
	logic             awr, wr, bv, arr, rv, done, hit, inh, rled, sled, ten, ers;
	logic [0:0][15:0] ao;
	pmc_eng_req_t     req;
	logic [2:0]       ops[$];
	int               err_count = 0, comparisons = 0, ne = 0, ns = 0;
	always #2.5 clk = ~clk;
	always @(posedge clk) begin
		if (req.go === 1'b1) ops.push_back(req.op);
		if (req.go === 1'b1 && req.step === 1'b1) ns++;
		if (ers === 1'b1) ne++;
	end
	pmc_mode_ctrl #(.NCH(1), .WDG_CYC(200), .BLINK_MIN(64), .BLINK_HALF(4), .MR_HOLD(16)) uut (
		.CLK(clk), .RESET_N(rst_n), .S_AXI_AWADDR(awa), .S_AXI_AWVALID(awv),
		.S_AXI_AWREADY(awr), .S_AXI_WDATA(wd), .S_AXI_WSTRB(ws), .S_AXI_WVALID(wv),
		.S_AXI_WREADY(wr), .S_AXI_BRESP(br), .S_AXI_BVALID(bv), .S_AXI_BREADY(bre),
		.S_AXI_ARADDR(ara), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arr), .S_AXI_RDATA(rdata),
		.S_AXI_RRESP(rr), .S_AXI_RVALID(rv), .S_AXI_RREADY(rre), .SWITCH_RUN(sw_run),
		.SWITCH_MR(sw_mr), .ENG_REQ(req), .ENG_DONE(done), .BRK_HIT(hit), .BRK_ID(bid),
		.WDG_KICK(done && !nokick), .OUT_INHIBIT(inh), .RUN_INDICATOR(rled), .STOP_LED(sled),
		.TIMER_EN(ten), .MEM_ERASE(ers), .AO_IN(ai), .AO_OUT(ao));
	pmc_eng_model eng (.CLK(clk), .RESET_N(rst_n), .REQ(req), .ARM(arm), .DONE(done), .HIT(hit));
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		comparisons++;
		if (s !== e) begin
			err_count++;
			$display("[ERR] t=%0t seen %h exp %h", $time, s, e);
		end
	endtask
	task automatic print_verdict();
		$display("counts: %0d compared, %0d mismatched", comparisons, err_count);
		if (err_count == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic tick(input int c);
		repeat (c) @(posedge clk);
	endtask
	task automatic wt(ref logic s);
		int k;
		k = 0;
		do begin @(posedge clk); k++; end while (s !== 1'b1 && k < 200);
		if (k >= 200) begin err_count++; print_verdict(); end
	endtask
	// Valid and payload stay up until the ready edge, then valid drops
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		awa <= a; wd <= d; awv <= 1; wv <= 1; bre <= 1;
		wt(awr);
		awv <= 0; wv <= 0;
		wt(bv);
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		ara <= a; arv <= 1; rre <= 1;
		wt(arr);
		arv <= 0;
		wt(rv);
		d = rdata;
		rsp = rr;
	endtask
	task automatic wmode(input logic [1:0] m);
		int k;
		k = 0;
		do begin rd_reg(ADDR_STATUS, rd); k++; end while (rd[1:0] !== m && k < 100);
		if (k >= 100) begin err_count++; print_verdict(); end
	endtask
	initial begin
		tick(2);
		rst_n <= 1;
		chk({inh, sled, rled, ten}, 4'hC);
		rd_reg(ADDR_STATUS, rd);
		chk(rd[1:0], PMC_STOP);
		rd_reg(ADDR_CYC_LIMIT, rd);
		chk(rd, 32'h3E8);
		rd_reg(8'h18, rd);
		chk(rsp, RESP_DECERR);
		$display("test reset done");
		sw_run <= 1;
		wr_reg(ADDR_CTRL, 32'h1);
		tick(1);
		chk({inh, sled}, 2'h2);
		wmode(PMC_RUN);
		chk({inh, sled, ten}, 3'h1);
		tick(80);
		chk({rled, ao}, 17'h11234);
		ai <= 16'h5A5A;
		tick(2);
		chk(ao, 16'h5A5A);
		chk({ops[0], ops[1], ops[2], ops[3], ops[4], ops[5], ops[6]}, {PH_CLR_IN, PH_REMOTE,
			PH_STARTUP, PH_CLR_OUT, PH_READ_IN, PH_MAIN, PH_WRITE_OUT});
		$display("test start done");
		wr_reg(ADDR_BRK, 32'h12);
		bid <= 2'h1;
		arm <= 1;
		wmode(PMC_HOLD);
		chk({inh, sled, ten}, 3'h6);
		wr_reg(ADDR_CTRL, 32'h5);
		tick(6);
		rd_reg(ADDR_STATUS, rd);
		chk({rd[7], rd[1:0], ns[1:0]}, 5'h09);
		wr_reg(ADDR_BRK, 32'hF);
		wr_reg(ADDR_CTRL, 32'h5);
		rd_reg(ADDR_STATUS, rd);
		chk({rd[7], ns[1:0]}, 3'h5);
		wr_reg(ADDR_CTRL, 32'h3);
		arm <= 0;
		wmode(PMC_RUN);
		$display("test hold done");
		nokick <= 1;
		tick(210);
		rd_reg(ADDR_STATUS, rd);
		chk({rd[5], rd[1:0]}, 3'h4);
		nokick <= 0;
		wr_reg(ADDR_CTRL, 32'h11);
		wmode(PMC_RUN);
		$display("test watchdog done");
		wr_reg(ADDR_CTRL, 32'h0);
		tick(2);
		chk({inh, ao}, 17'h10000);
		wr_reg(ADDR_AO_CFG, {30'h0, AO_TYPE_I420});
		tick(2);
		chk(ao, AO_LIVE_ZERO_DEF);
		wr_reg(ADDR_AO_SUBST, 32'hABCD);
		wr_reg(ADDR_AO_CFG, 32'h100);
		tick(2);
		chk(ao, 16'hABCD);
		$display("test stop done");
		sw_run <= 0;
		ws <= 4'hE;
		wr_reg(ADDR_CTRL, 32'h8);
		ws <= 4'hF;
		tick(3);
		chk(ne, 0);
		wr_reg(ADDR_CTRL, 32'h8);
		tick(3);
		chk(ne, 1);
		sw_mr <= 1;
		tick(20);
		sw_mr <= 0;
		tick(3);
		sw_mr <= 1;
		tick(3);
		chk(ne, 2);
		$display("test erase done");
		print_verdict();
	end
endmodule
